// file: rtl/smsi_regs.svh
// Named constants for the two-wire serial interface
`ifndef SMSI_REGS_SVH
`define SMSI_REGS_SVH
// Timing source ticks that make one SCL low or high phase (one full period at least)
`define SMSI_PHASE_TICKS 4'h2
// Idle ticks with both lines high before the bus counts as free
`define SMSI_FREE_TICKS 4'ha
// Saturation value of the phase tick counter
`define SMSI_TICK_MAX 4'hf
// Bit positions inside a byte frame; bit eight is the acknowledge bit
`define SMSI_BIT_FIRST 4'h0
`define SMSI_BIT_LAST 4'h7
`define SMSI_BIT_ACK 4'h8
// Count held after a START so that its own SCL fall opens bit zero
`define SMSI_BIT_PRE 4'hf
// Position of the direction flag in the address byte and its read value
`define SMSI_DIR_POS 0
`define SMSI_DIR_READ 1'b1
// Position of the stop request flag in a transmit word
`define SMSI_STOP_POS 8
// Level of a released two-wire line
`define SMSI_LINE_IDLE 1'b1
`endif

// file: rtl/smsi_pkg.sv
// Types shared by the two-wire serial interface modules
package smsi_pkg;

  // Sequencer states, Gray coded along the master path
  typedef enum logic [3:0] {
    SMSI_IDLE        = 4'h0,
    SMSI_M_START     = 4'h1,
    SMSI_M_LOW       = 4'h3,
    SMSI_M_HIGH_WAIT = 4'h2,
    SMSI_M_HIGH      = 4'h6,
    SMSI_M_STOP_LOW  = 4'h7,
    SMSI_M_STOP_HIGH = 4'h5,
    SMSI_M_STOP_SDA  = 4'h4,
    SMSI_S_BIT       = 4'hc,
    SMSI_S_WAIT      = 4'hd
  } smsi_state_t;

  // Whole state of the core
  typedef struct packed {
    smsi_state_t st;
    logic [3:0] ph;
    logic [3:0] free_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic tx_mode;
    logic is_addr;
    logic rd_dir;
    logic stop_flag;
    logic need_load;
    logic master;
    logic addressed;
    logic inh;
    logic busy;
    logic ack_rx;
    logic line_o;
    logic scl_oe;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_is_addr;
    logic ev_byte;
    logic ev_ack;
    logic ev_arb;
    logic ev_start;
    logic ev_stop;
  } smsi_core_t;

endpackage

// file: rtl/smsi_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`include "smsi_regs.svh"
module smsi_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous inputs and synchronised outputs
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smsi_sync_t;

  smsi_sync_t q;
  smsi_sync_t d;

  // Each bit runs through its own pair of stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        d.s1[i] = d_in[i];
        d.s2[i] = q.s1[i];
      end
    end
  endgenerate

  // Stages idle at the released line level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= {(2 * W){`SMSI_LINE_IDLE}};
    end else begin
      q <= d;
    end
  end

  assign d_out = q.s2;

endmodule

// file: rtl/smsi_fifo.sv
// Show-ahead FIFO with registered read data and registered ready
`timescale 1ns/1ps
module smsi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
    logic rdy;
  } smsi_fifo_t;

  smsi_fifo_t q;
  smsi_fifo_t d;

  // Write into the array, refill the output register when it empties or is taken
  always_comb begin
    logic [AW:0] c;
    c = q.cnt;
    d = q;
    if (in_valid && q.rdy) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
      c = c + 1'b1;
    end
    if (!q.ov || out_ready) begin
      if (q.cnt != '0) begin
        d.od = q.mem[q.rp];
        d.rp = q.rp + 1'b1;
        d.ov = 1'b1;
        c = c - 1'b1;
      end else begin
        d.ov = 1'b0;
      end
    end
    d.cnt = c;
    d.rdy = (c != (AW + 1)'(DEPTH));
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = q.ov;
  assign out_data = q.od;

endmodule

// file: rtl/smsi_core.sv
// Byte-oriented two-wire serial interface, master and slave, multi-master safe
//
// Contract
// - Host exchanges whole bytes; hardware shifts bits
// - Bit rate up to system clock over twenty
// - Low phase of SCL may be stretched
// - Master, slave or both on shared bus
// - Software or hardware address match and acknowledge
// - Lines only pulled low, otherwise released
// - Master starts transfers and makes every clock
// - Whoever sends START and address becomes master
// - START, address with direction, data bytes, STOP
// - Receiver acknowledges with SDA low, high is NACK
// - Direction flag one reads, zero writes
// - Each byte waits for the other side's acknowledge
// - Master ends transfer with STOP, freeing bus
// - Sender drives data bits; receiver drives acknowledge
// - Master starts only on a free bus
// - Released high bit seen low loses arbitration
// - Loser turns slave and receives if addressed
// - Bus free after over ten idle ticks
// - One tick period sets least SCL low, high
// - Host signalled once per address or data byte
`timescale 1ns/1ps
`include "smsi_regs.svh"
module smsi_core #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration levels
  input wire logic enable,
  input wire logic slave_inhibit,
  input wire logic hw_ack_en,
  input wire logic sw_ack,
  input wire logic [6:0] own_addr,
  input wire logic free_detect_en,
  // Timing source overflow pulse
  input wire logic time_tick,
  // Master request
  input wire logic master_go,
  // Transmit bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_stop,
  output logic tx_ready,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_is_addr,
  // Events and status
  output logic ev_byte,
  output logic ev_ack,
  output logic ev_arb_lost,
  output logic ev_start,
  output logic ev_stop,
  output logic bus_busy,
  output logic master_active,
  output logic slave_addressed,
  // Two-wire pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  smsi_pkg::smsi_core_t q;
  smsi_pkg::smsi_core_t d;
  logic scl_s;
  logic sda_s;
  logic pop;
  logic f_valid;
  logic [8:0] f_data;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic ph_done;
  logic addr_match;

  // Pin synchronisers
  smsi_sync #(.W(2)) i_smsi_sync (
    .clk(clk),
    .resetn(resetn),
    .d_in({scl_i, sda_i}),
    .d_out({scl_s, sda_s})
  );

  // Transmit byte buffer, drained one byte at a time by the sequencer
  smsi_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) i_smsi_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_data({tx_stop, tx_data}),
    .in_ready(tx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop)
  );

  // Line events seen on the synchronised pins
  assign rise = !q.scl_p && scl_s;
  assign fall = q.scl_p && !scl_s;
  assign start_det = q.scl_p && scl_s && q.sda_p && !sda_s;
  assign stop_det = q.scl_p && scl_s && !q.sda_p && sda_s;
  assign ph_done = time_tick && (q.ph == (`SMSI_PHASE_TICKS - 4'h1));
  assign addr_match = (q.sh[7:1] == own_addr);

  // Next state of the whole interface
  always_comb begin
    d = q;
    pop = 1'b0;
    d.rx_valid = 1'b0;
    d.ev_byte = 1'b0;
    d.ev_arb = 1'b0;
    d.ev_start = 1'b0;
    d.ev_stop = 1'b0;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    if (time_tick && (q.ph != `SMSI_TICK_MAX)) begin
      d.ph = q.ph + 4'h1;
    end
    // Bus busy tracking and free detection
    if (scl_s && sda_s && free_detect_en) begin
      if (time_tick) begin
        if (q.free_cnt >= `SMSI_FREE_TICKS) begin
          d.busy = 1'b0;
        end else begin
          d.free_cnt = q.free_cnt + 4'h1;
        end
      end
    end else begin
      d.free_cnt = '0;
    end
    if (stop_det) begin
      d.busy = 1'b0;
    end
    if (start_det) begin
      d.busy = 1'b1;
    end
    case (q.st)
      smsi_pkg::SMSI_IDLE: begin
        if (enable && master_go && !q.busy && f_valid) begin
          d.st = smsi_pkg::SMSI_M_START;
          d.sda_oe = 1'b1;
          d.ph = '0;
          d.master = 1'b1;
          d.ev_start = 1'b1;
        end
      end
      smsi_pkg::SMSI_M_START: begin
        if (ph_done) begin
          d.st = smsi_pkg::SMSI_M_LOW;
          d.scl_oe = 1'b1;
          d.ph = '0;
          d.sh = f_data[7:0];
          d.stop_flag = f_data[`SMSI_STOP_POS];
          d.rd_dir = (f_data[`SMSI_DIR_POS] == `SMSI_DIR_READ);
          pop = 1'b1;
          d.bit_cnt = `SMSI_BIT_FIRST;
          d.tx_mode = 1'b1;
          d.is_addr = 1'b1;
          d.need_load = 1'b0;
        end
      end
      smsi_pkg::SMSI_M_LOW: begin
        d.scl_oe = 1'b1;
        if (q.need_load) begin
          // Hold SCL low until the host supplies the next byte
          d.ph = '0;
          if (f_valid) begin
            d.sh = f_data[7:0];
            d.stop_flag = f_data[`SMSI_STOP_POS];
            pop = 1'b1;
            d.need_load = 1'b0;
          end
        end else begin
          if (q.bit_cnt == `SMSI_BIT_ACK) begin
            d.sda_oe = !q.tx_mode && master_go;
          end else begin
            d.sda_oe = q.tx_mode && !q.sh[7];
          end
          if (ph_done) begin
            d.scl_oe = 1'b0;
            d.st = smsi_pkg::SMSI_M_HIGH_WAIT;
          end
        end
      end
      smsi_pkg::SMSI_M_HIGH_WAIT: begin
        if (scl_s) begin
          d.st = smsi_pkg::SMSI_M_HIGH;
          d.ph = '0;
        end
      end
      smsi_pkg::SMSI_M_HIGH: begin
        if ((q.bit_cnt != `SMSI_BIT_ACK) && q.tx_mode && q.sh[7] && !sda_s) begin
          // Lost to another master: drop both lines and listen on
          d.sda_oe = 1'b0;
          d.master = 1'b0;
          d.tx_mode = 1'b0;
          d.ev_arb = 1'b1;
          d.sh = {q.sh[6:0], sda_s};
          d.st = smsi_pkg::SMSI_S_BIT;
        end else if (ph_done) begin
          d.scl_oe = 1'b1;
          d.ph = '0;
          d.st = smsi_pkg::SMSI_M_LOW;
          if (q.bit_cnt != `SMSI_BIT_ACK) begin
            d.sh = {q.sh[6:0], sda_s};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else begin
            d.bit_cnt = `SMSI_BIT_FIRST;
            d.is_addr = 1'b0;
            d.ev_byte = 1'b1;
            // Our acknowledge stays until SCL is low; the next low phase lets it go
            d.ev_ack = q.tx_mode ? !sda_s : q.sda_oe;
            if (!q.tx_mode) begin
              d.rx_valid = 1'b1;
              d.rx_data = q.sh;
              d.rx_is_addr = 1'b0;
            end
            if ((q.tx_mode && (sda_s || q.stop_flag)) || (!q.tx_mode && !q.sda_oe)) begin
              d.st = smsi_pkg::SMSI_M_STOP_LOW;
            end else if (q.tx_mode && q.is_addr && q.rd_dir) begin
              d.tx_mode = 1'b0;
            end else if (q.tx_mode) begin
              d.need_load = 1'b1;
            end
          end
        end
      end
      smsi_pkg::SMSI_M_STOP_LOW: begin
        d.scl_oe = 1'b1;
        d.sda_oe = 1'b1;
        if (ph_done) begin
          d.scl_oe = 1'b0;
          d.st = smsi_pkg::SMSI_M_STOP_HIGH;
        end
      end
      smsi_pkg::SMSI_M_STOP_HIGH: begin
        if (!scl_s) begin
          d.ph = '0;
        end else if (ph_done) begin
          d.sda_oe = 1'b0;
          d.ph = '0;
          d.st = smsi_pkg::SMSI_M_STOP_SDA;
        end
      end
      smsi_pkg::SMSI_M_STOP_SDA: begin
        if (ph_done) begin
          d.master = 1'b0;
          d.st = smsi_pkg::SMSI_IDLE;
        end
      end
      smsi_pkg::SMSI_S_BIT: begin
        d.scl_oe = q.need_load;
        if (q.need_load && f_valid) begin
          d.sh = f_data[7:0];
          pop = 1'b1;
          d.need_load = 1'b0;
          d.sda_oe = !f_data[7];
        end
        if (rise) begin
          if (q.bit_cnt != `SMSI_BIT_ACK) begin
            d.sh = {q.sh[6:0], sda_s};
          end else begin
            d.ack_rx = !sda_s;
          end
        end
        if (fall) begin
          if (q.bit_cnt == `SMSI_BIT_LAST) begin
            d.bit_cnt = `SMSI_BIT_ACK;
            d.sda_oe = 1'b0;
            if (!q.tx_mode) begin
              if (q.is_addr) begin
                d.addressed = !q.inh && (hw_ack_en ? addr_match : sw_ack);
                d.sda_oe = !q.inh && (hw_ack_en ? addr_match : sw_ack);
                d.rd_dir = (q.sh[`SMSI_DIR_POS] == `SMSI_DIR_READ);
              end else begin
                d.sda_oe = hw_ack_en || sw_ack;
              end
              d.rx_valid = !q.inh;
              d.ev_byte = !q.inh;
              d.rx_data = q.sh;
              d.rx_is_addr = q.is_addr;
            end
          end else if (q.bit_cnt == `SMSI_BIT_ACK) begin
            d.bit_cnt = `SMSI_BIT_FIRST;
            d.sda_oe = 1'b0;
            d.is_addr = 1'b0;
            if (q.tx_mode) begin
              d.ev_byte = 1'b1;
              d.ev_ack = q.ack_rx;
              if (q.ack_rx) begin
                d.need_load = 1'b1;
              end else begin
                d.st = smsi_pkg::SMSI_S_WAIT;
              end
            end else if (!q.addressed) begin
              d.st = smsi_pkg::SMSI_S_WAIT;
            end else if (q.is_addr && q.rd_dir) begin
              d.tx_mode = 1'b1;
              d.need_load = 1'b1;
            end
          end else begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            d.sda_oe = q.tx_mode && !q.sh[7];
          end
        end
      end
      smsi_pkg::SMSI_S_WAIT: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
      end
      default: begin
        d.st = smsi_pkg::SMSI_IDLE;
      end
    endcase
    // Start and stop seen by a non-master restart or end the slave sequence
    if (!q.master) begin
      if (start_det) begin
        d.st = smsi_pkg::SMSI_S_BIT;
        d.bit_cnt = `SMSI_BIT_PRE; // Start's own SCL fall is not a data bit
        d.tx_mode = 1'b0;
        d.is_addr = 1'b1;
        d.addressed = 1'b0;
        d.need_load = 1'b0;
        d.inh = slave_inhibit;
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
      end else if (stop_det && (q.st != smsi_pkg::SMSI_IDLE)) begin
        d.ev_stop = q.addressed;
        d.addressed = 1'b0;
        d.need_load = 1'b0;
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        d.st = smsi_pkg::SMSI_IDLE;
      end
    end
    // Disabled interface lets go of both lines
    if (!enable) begin
      d.st = smsi_pkg::SMSI_IDLE;
      d.master = 1'b0;
      d.addressed = 1'b0;
      d.need_load = 1'b0;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register; pins only ever pull low
  assign rx_valid = q.rx_valid;
  assign rx_data = q.rx_data;
  assign rx_is_addr = q.rx_is_addr;
  assign ev_byte = q.ev_byte;
  assign ev_ack = q.ev_ack;
  assign ev_arb_lost = q.ev_arb;
  assign ev_start = q.ev_start;
  assign ev_stop = q.ev_stop;
  assign bus_busy = q.busy;
  assign master_active = q.master;
  assign slave_addressed = q.addressed;
  assign scl_o = q.line_o;
  assign sda_o = q.line_o;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;

endmodule

// file: sim/smsi_core_props.sv
// Concurrent checks on the ports of the two-wire interface core
`timescale 1ns/1ps
module smsi_core_props #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Watched levels and events
  input wire logic enable,
  input wire logic ev_start,
  input wire logic ev_byte,
  input wire logic rx_valid,
  input wire logic ev_arb_lost,
  input wire logic bus_busy,
  input wire logic master_active,
  // Line drivers
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Lines are only ever pulled low
  AST_LINES_LOW: assert property (!scl_o && !sda_o)
    else $error("line output not low");
  AST_OFF_RELEASE: assert property (!enable ##1 !enable |-> !scl_oe && !sda_oe)
    else $error("lines held while disabled");
  // Start pulls data with the clock released, only on a free bus
  AST_START_FORM: assert property (ev_start |-> sda_oe && !scl_oe)
    else $error("start not formed with clock high");
  AST_START_FREE: assert property (ev_start |-> !$past(bus_busy))
    else $error("start on a busy bus");
  // Byte event and receive strobe last one cycle
  AST_BYTE_ONCE: assert property (ev_byte |=> !ev_byte)
    else $error("byte event longer than a cycle");
  AST_RX_ONCE: assert property (rx_valid |=> !rx_valid)
    else $error("receive strobe longer than a cycle");
  // Master low phase lasts at least six clocks
  AST_LOW_MIN: assert property ($rose(scl_oe) && master_active |-> scl_oe [*6])
    else $error("clock low phase too short");
  AST_ARB_YIELD: assert property (ev_arb_lost |-> ##[0:2] (!master_active && !scl_oe))
    else $error("master role kept after losing");
endmodule
bind smsi_core smsi_core_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_smsi_core_props (
  .clk(clk), .resetn(resetn), .enable(enable), .ev_start(ev_start), .ev_byte(ev_byte),
  .rx_valid(rx_valid), .ev_arb_lost(ev_arb_lost), .bus_busy(bus_busy),
  .master_active(master_active), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
  .sda_oe(sda_oe));

// file: sim/smsi_bus_model.sv
// Behavioural slave device on the far side of the two-wire bus
`timescale 1ns/1ps
module smsi_bus_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  // Clock and resolved lines
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  // Behaviour controls
  input wire logic nack_all,
  input wire logic [7:0] stretch,
  input wire logic [7:0] rd_byte,
  // Pulls (high pulls low) and last byte written
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got
);
  logic scl_q = 1'b1, sda_q = 1'b1, act = 1'b0, rd = 1'b0, sel = 1'b0;
  logic [3:0] bitc = 4'h0;
  logic [7:0] sh = 8'h00, tx = 8'h00, nb = 8'h00, hold = 8'h00;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    got = 8'h00;
  end
  // Follow the frame on the system clock and answer as the addressed slave
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold != 8'h00) hold <= hold - 8'h01;
    else scl_pull <= 1'b0;
    if (scl && scl_q && sda_q && !sda) begin
      act <= 1'b1; // Start opens a frame
      bitc <= 4'hf; // Start's own SCL fall opens bit zero
      nb <= 8'h00;
      rd <= 1'b0;
      sel <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      act <= 1'b0; // Stop frees the bus
      sda_pull <= 1'b0;
    end else if (act && scl && !scl_q) begin
      if (bitc < 4'h8) sh <= {sh[6:0], sda}; // MSB first
      else if (rd && sel && sda) act <= 1'b0; // Master NACK ends sending
    end else if (act && !scl && scl_q) begin
      if (stretch != 8'h00) begin
        scl_pull <= 1'b1; // Extend the low phase
        hold <= stretch;
      end
      bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
      if (bitc == 4'h7) begin
        sda_pull <= 1'b0;
        if (nb == 8'h00) begin
          sel <= sh[7:1] == ADDR && !nack_all;
          rd <= sh[0]; // One reads
          sda_pull <= sh[7:1] == ADDR && !nack_all; // Receiver acks low
        end else if (!rd) begin
          got <= sh;
          sda_pull <= sel;
        end
      end else if (bitc == 4'h8) begin
        nb <= nb + 8'h01;
        sda_pull <= rd && sel && !rd_byte[7]; // Sender owns data bits
        tx <= {rd_byte[6:0], 1'b0};
      end else if (rd && sel) begin
        sda_pull <= !tx[7];
        tx <= {tx[6:0], 1'b0};
      end else sda_pull <= 1'b0;
    end
  end
endmodule

// file: sim/test_smsi_core.sv
// Self-checking bench for the two-wire interface core
`timescale 1ns/1ps
module test_smsi_core;
  logic clk = 1'b0, resetn = 1'b0, enable = 1'b0, slave_inhibit = 1'b0, hw_ack_en = 1'b1;
  logic sw_ack = 1'b1, free_detect_en = 1'b1, time_tick = 1'b0, master_go = 1'b0;
  logic tx_valid = 1'b0, tx_stop = 1'b0, nack_all = 1'b0, tb_scl = 1'b0, tb_sda = 1'b0;
  logic [7:0] tx_data = 8'h00, stretch = 8'h00, rd_byte = 8'h00, last_rx = 8'h00;
  logic [6:0] own_addr = 7'h21;
  logic tx_ready, rx_valid, rx_is_addr, ev_byte, ev_ack, ev_arb_lost, ev_start, ev_stop;
  logic bus_busy, master_active, slave_addressed, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  logic [7:0] rx_data, got;
  int mismatches = 0, num_checks = 0, n_byte = 0, n_ack = 0, n_rx = 0, n_stop = 0, tcnt = 0;
  // Wired-AND bus lines with pull-ups
  wire scl = !(scl_oe || m_scl || tb_scl);
  wire sda = !(sda_oe || m_sda || tb_sda);
  smsi_core i_smsi_core (.clk(clk), .resetn(resetn), .enable(enable),
    .slave_inhibit(slave_inhibit), .hw_ack_en(hw_ack_en), .sw_ack(sw_ack),
    .own_addr(own_addr), .free_detect_en(free_detect_en), .time_tick(time_tick),
    .master_go(master_go), .tx_valid(tx_valid), .tx_data(tx_data), .tx_stop(tx_stop),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_is_addr(rx_is_addr),
    .ev_byte(ev_byte), .ev_ack(ev_ack), .ev_arb_lost(ev_arb_lost), .ev_start(ev_start),
    .ev_stop(ev_stop), .bus_busy(bus_busy), .master_active(master_active),
    .slave_addressed(slave_addressed), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  smsi_bus_model i_smsi_bus_model (.clk(clk), .scl(scl), .sda(sda), .nack_all(nack_all),
    .stretch(stretch), .rd_byte(rd_byte), .scl_pull(m_scl), .sda_pull(m_sda), .got(got));
  // System clock
  initial begin
    forever #25 clk = !clk;
  end
  // Timing source every eighth clock and event counters
  always @(posedge clk) begin
    tcnt <= (tcnt == 7) ? 0 : tcnt + 1;
    time_tick <= (tcnt == 7);
    if (ev_byte) n_byte <= n_byte + 1;
    if (ev_byte && ev_ack === 1'b1) n_ack <= n_ack + 1;
    if (rx_valid) n_rx <= n_rx + 1;
    if (rx_valid) last_rx <= rx_data;
    if (ev_stop) n_stop <= n_stop + 1;
  end
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return master_active;
      1: return bus_busy;
      2: return rx_valid && !rx_is_addr;
      3: return scl_oe;
      default: return ev_arb_lost;
    endcase
  endfunction
  // Bounded wait for a design level
  task automatic wait_lvl(input int k, input logic v);
    int i;
    for (i = 0; i < 20000 && sig(k) !== v; i++) @(posedge clk);
    if (sig(k) !== v) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic push(input logic stp, input logic [7:0] d);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_stop <= stp;
    tx_data <= d;
    @(posedge clk);
    chk(8'(tx_ready), 8'h01);
    tx_valid <= 1'b0;
  endtask
  task automatic run_master();
    master_go <= 1'b1;
    wait_lvl(0, 1'b1);
    master_go <= 1'b0;
    wait_lvl(0, 1'b0);
  endtask
  // Bench acting as bus master at 400 ns per bit
  task automatic bb_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      tb_sda <= !b[i];
      repeat (2) @(posedge clk);
      tb_scl <= 1'b0;
      repeat (4) @(posedge clk);
      tb_scl <= 1'b1;
      repeat (2) @(posedge clk);
    end
    tb_sda <= 1'b0;
    repeat (2) @(posedge clk);
    tb_scl <= 1'b0;
    repeat (4) @(posedge clk);
    a = sda;
    tb_scl <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic bb_frame(input logic [7:0] b0, input logic [7:0] b1, input int n);
    logic a;
    logic e;
    tb_sda <= 1'b1;
    repeat (4) @(posedge clk);
    tb_scl <= 1'b1;
    repeat (2) @(posedge clk);
    bb_byte(b0, a);
    e = !slave_inhibit && (hw_ack_en ? (b0[7:1] == own_addr) : sw_ack);
    chk(8'(a), 8'(!e));
    chk(8'(slave_addressed), 8'(e));
    if (n > 1) bb_byte(b1, a);
    if (n > 1) chk(8'(a), 8'h00);
    tb_sda <= 1'b1;
    repeat (2) @(posedge clk);
    tb_scl <= 1'b0;
    repeat (4) @(posedge clk);
    tb_sda <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    chk(8'(tx_ready), 8'h00);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    enable <= 1'b1;
    // Fill the buffer to refusal, then drain it in one stretched write
    stretch <= 8'h0c;
    push(1'b0, 8'hb4);
    for (int i = 1; i < 17; i++) push(i == 16, 8'(i * 13));
    repeat (3) @(posedge clk);
    chk(8'(tx_ready), 8'h00);
    run_master();
    chk(8'(n_byte), 8'd17);
    chk(8'(n_ack), 8'd17);
    chk(got, 8'(16 * 13));
    // Read two bytes, acking the first only
    stretch <= 8'h00;
    rd_byte <= 8'h69;
    push(1'b0, 8'hb5);
    master_go <= 1'b1;
    wait_lvl(2, 1'b1);
    master_go <= 1'b0;
    wait_lvl(0, 1'b0);
    chk(last_rx, 8'h69);
    chk(8'(n_rx), 8'd2);
    // Address refused by the slave ends the transfer
    nack_all <= 1'b1;
    push(1'b0, 8'hb4);
    run_master();
    chk(8'(n_byte), 8'd21);
    chk(8'(n_ack), 8'd19);
    // Lose arbitration on the first released address bit
    nack_all <= 1'b0;
    push(1'b1, 8'hb4);
    master_go <= 1'b1;
    wait_lvl(3, 1'b1);
    tb_sda <= 1'b1;
    wait_lvl(4, 1'b1);
    master_go <= 1'b0;
    repeat (40) @(posedge clk);
    chk(8'(master_active), 8'h00);
    tb_sda <= 1'b0;
    wait_lvl(1, 1'b0);
    // Slave receive with hardware address match, then a foreign address
    bb_frame(8'h42, 8'h5e, 2);
    chk(last_rx, 8'h5e);
    chk(8'(n_stop), 8'd1);
    bb_frame(8'h44, 8'h00, 1);
    // Software acknowledge, then inhibited slave events
    hw_ack_en <= 1'b0;
    bb_frame(8'h44, 8'h33, 2);
    chk(last_rx, 8'h33);
    slave_inhibit <= 1'b1;
    hw_ack_en <= 1'b1;
    bb_frame(8'h42, 8'h00, 1);
    chk(8'(n_stop), 8'd2);
    chk(8'(n_rx), 8'd7);
    stop_test();
  end
endmodule
